// >>> include/simd_adder_regs.svh
`ifndef SIMD_ADDER_REGS_SVH
`define SIMD_ADDER_REGS_SVH

// Register byte offsets on the APB port
`define OFS_CTRL        8'h00
`define OFS_PATTERN_LO  8'h04
`define OFS_PATTERN_HI  8'h08
`define OFS_MASK_LO     8'h0c
`define OFS_MASK_HI     8'h10
`define OFS_STATUS      8'h14
`define OFS_RESULT_LO   8'h18
`define OFS_RESULT_HI   8'h1c

// Control word: writable bits and reset value
// [1:0] mult usage, [3:2] lane split, [5:4] autoclear, [7:6] mask source,
// [8] pattern source, [9] matcher used, [10] third operand stage count,
// [11] result stage used, [12] subtract
`define CTRL_WMASK      32'h0000_1fff
`define CTRL_RESET      32'h0000_0c01

// Status word bit positions
`define ST_DETECT       0
`define ST_DETECT_PREV  1
`define ST_CONFLICT     2
`define ST_CARRY_LSB    4

// Static comparator values after reset
`define PATTERN_RESET   48'h0000_0000_0000
`define MASK_RESET      48'h3fff_ffff_ffff

`endif

// >>> include/simd_adder_pkg.sv
package simd_adder_pkg;

  typedef enum logic [1:0] {
    mult_never   = 2'b00,
    mult_always  = 2'b01,
    mult_dynamic = 2'b10
  } mult_usage_t;

  typedef enum logic [1:0] {
    single_wide_lane   = 2'b00,
    dual_half_lanes    = 2'b01,
    quad_quarter_lanes = 2'b10
  } adder_lane_split_t;

  typedef enum logic [1:0] {
    clear_none       = 2'b00,
    clear_on_match   = 2'b01,
    clear_on_unmatch = 2'b10
  } match_autoclear_policy_t;

  typedef enum logic [1:0] {
    mask_static                = 2'b00,
    mask_third_operand         = 2'b01,
    inverted_operand_shift_one = 2'b10,
    inverted_operand_shift_two = 2'b11
  } mask_source_t;

  typedef enum logic {
    pattern_static        = 1'b0,
    pattern_third_operand = 1'b1
  } pattern_source_t;

  typedef struct packed {
    logic [18:0]             reserved;
    logic                    subtract;
    logic                    result_stage_used;
    logic                    third_operand_stage_count;
    logic                    matcher_used;
    pattern_source_t         pattern_source;
    mask_source_t            mask_source;
    match_autoclear_policy_t match_autoclear_policy;
    adder_lane_split_t       adder_lane_split;
    mult_usage_t             mult_usage;
  } ctrl_t;

  typedef struct packed {
    logic [47:0] pattern;
    logic [47:0] mask;
  } match_static_t;

endpackage

// >>> rtl/pattern_matcher.sv
`timescale 1ns/1ps
`default_nettype none

module pattern_matcher
  import simd_adder_pkg::*;
(
  input  wire logic [47:0]   value,
  input  wire logic [47:0]   third_operand,
  input  wire match_static_t static_cfg,
  input  wire mask_source_t  mask_source,
  input  wire pattern_source_t pattern_source,
  output logic               match
);

  logic [47:0] mask_sel;
  logic [47:0] pattern_sel;

  always_comb begin
    case (mask_source)
      mask_third_operand:         mask_sel = third_operand;
      inverted_operand_shift_one: mask_sel = {~third_operand[46:0], 1'b0};
      inverted_operand_shift_two: mask_sel = {~third_operand[45:0], 2'b00};
      default:                    mask_sel = static_cfg.mask;
    endcase
  end

  assign pattern_sel = (pattern_source == pattern_third_operand) ? third_operand
                                                                 : static_cfg.pattern;

  // Masked-out bits are forced equal so only compared bits can fail
  assign match = &(~(value ^ pattern_sel) | mask_sel);

endmodule // pattern_matcher

`default_nettype wire

// >>> rtl/simd_adder_pattern_match.sv
`timescale 1ns/1ps
`default_nettype none

`include "simd_adder_regs.svh"

// Notes on behaviour
// - Multiplier usage is never, always or dynamic, always after reset, and never gates it off.
// - In dynamic usage the mult_select input picks product or concatenation each cycle.
// - The adder runs as one 48-bit, two 24-bit or four 12-bit lanes, single lane after reset.
// - Multiply-then-add works in the single wide lane setting.
// - With autoclear enabled and the result stage used, a detect event clears the result register at the next edge.
// - Clear-on-match clears the result on the cycle after the comparison matched.
// - Clear-on-unmatch clears only when a match is lost after a matching cycle.
// - A mask bit of one excludes that bit from the comparison, zero includes it.
// - A static 48-bit pattern set by software is available to the comparator.
// - The mask is the static mask, the third operand, or its inverse shifted by one or two.
// - Rounding masks come from the third operand after its optional stage.
// - The pattern is the static pattern or the third operand, static after reset.
// - The matcher-used bit is stored and read back but changes no behaviour.
// - The result register is selectable, loads under its enable and clears synchronously.
// - The third operand stage is optional, loads under its enable and clears synchronously.
module simd_adder_pattern_match
  import simd_adder_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [29:0] op_a,
  input  wire logic [17:0] op_b,
  input  wire logic [47:0] op_c,
  input  wire logic        mult_select,
  input  wire logic        third_operand_stage_enable,
  input  wire logic        third_operand_stage_clear,
  input  wire logic        output_stage_enable,
  input  wire logic        output_stage_clear,
  output logic [47:0]      result,
  output logic [3:0]       lane_carry,
  output logic             pattern_detect,
  output logic             config_conflict
);

  ctrl_t         ctrl_ff;
  match_static_t static_ff;
  logic [31:0]   prdata_ff;
  logic [47:0]   third_stage_ff;
  logic [47:0]   third_operand;
  logic [47:0]   result_ff;
  logic [47:0]   nxt_result;
  logic [3:0]    carry_ff;
  logic          detect_ff;
  logic          detect_prev_ff;
  logic          nxt_detect;
  logic          mult_active;
  logic          use_product;
  logic [24:0]   mult_a;
  logic [17:0]   mult_b;
  logic [42:0]   product;
  logic [47:0]   x_operand;
  logic [47:0]   x_eff;
  logic [3:0]    lane_start;
  logic [4:0]    carry_chain;
  logic [3:0]    seg_carry;
  logic [47:0]   sum;
  logic          autoclear;
  logic          result_load;
  logic          wr_en;
  logic          rd_setup;
  logic          addr_hit;
  logic [31:0]   rd_mux;
  logic [31:0]   status_word;
  logic [3:0]    nxt_carry;
  logic          result_clear;
  logic          lanes_split;
  logic [47:0]   product_ext;
  logic [47:0]   concat_ab;
  logic          wr_ctrl;
  logic          wr_pattern_lo;
  logic          wr_pattern_hi;
  logic          wr_mask_lo;
  logic          wr_mask_hi;

  // ---------------- APB slave ----------------
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  // One strobe per writable register keeps each storage block simple
  assign wr_ctrl       = wr_en && (paddr == `OFS_CTRL);
  assign wr_pattern_lo = wr_en && (paddr == `OFS_PATTERN_LO);
  assign wr_pattern_hi = wr_en && (paddr == `OFS_PATTERN_HI);
  assign wr_mask_lo    = wr_en && (paddr == `OFS_MASK_LO);
  assign wr_mask_hi    = wr_en && (paddr == `OFS_MASK_HI);
  // Zero wait states: every access completes in its first access cycle
  assign pready   = 1'b1;

  // Unmapped offsets read as zero and are flagged with pslverr
  always_comb begin
    addr_hit = 1'b1;
    if (paddr == `OFS_CTRL) begin
      rd_mux = ctrl_ff;
    end else if (paddr == `OFS_PATTERN_LO) begin
      rd_mux = static_ff.pattern[31:0];
    end else if (paddr == `OFS_PATTERN_HI) begin
      rd_mux = {16'h0000, static_ff.pattern[47:32]};
    end else if (paddr == `OFS_MASK_LO) begin
      rd_mux = static_ff.mask[31:0];
    end else if (paddr == `OFS_MASK_HI) begin
      rd_mux = {16'h0000, static_ff.mask[47:32]};
    end else if (paddr == `OFS_STATUS) begin
      rd_mux = status_word;
    end else if (paddr == `OFS_RESULT_LO) begin
      rd_mux = result_ff[31:0];
    end else if (paddr == `OFS_RESULT_HI) begin
      rd_mux = {16'h0000, result_ff[47:32]};
    end else begin
      rd_mux   = 32'h0000_0000;
      addr_hit = 1'b0;
    end
  end

  assign pslverr = psel & penable & ~addr_hit;

  // Read data is captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_ff <= rd_mux;
    end
  end

  assign prdata = prdata_ff;

  // Reserved control bits are dropped on write so they read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= ctrl_t'(`CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl_ff <= ctrl_t'(pwdata & `CTRL_WMASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      static_ff.pattern <= `PATTERN_RESET;
      static_ff.mask    <= `MASK_RESET;
    end else if (wr_pattern_lo) begin
      static_ff.pattern[31:0] <= pwdata;
    end else if (wr_pattern_hi) begin
      static_ff.pattern[47:32] <= pwdata[15:0];
    end else if (wr_mask_lo) begin
      static_ff.mask[31:0] <= pwdata;
    end else if (wr_mask_hi) begin
      static_ff.mask[47:32] <= pwdata[15:0];
    end
  end

  // Matcher-used bit sits in ctrl_ff for readback only
  always_comb begin
    status_word                     = 32'h0000_0000;
    status_word[`ST_DETECT]         = detect_ff;
    status_word[`ST_DETECT_PREV]    = detect_prev_ff;
    status_word[`ST_CONFLICT]       = config_conflict;
    status_word[`ST_CARRY_LSB +: 4] = carry_ff;
  end

  // Split lanes with the multiplier in use give meaningless results
  // Split code 11 runs as the single lane, so it is no conflict
  assign lanes_split     = (ctrl_ff.adder_lane_split == dual_half_lanes) ||
                           (ctrl_ff.adder_lane_split == quad_quarter_lanes);
  assign config_conflict = lanes_split & mult_active;

  // ---------------- Third operand stage ----------------
  // Clear outranks enable, as on the result stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      third_stage_ff <= 48'h0000_0000_0000;
    end else if (third_operand_stage_clear) begin
      third_stage_ff <= 48'h0000_0000_0000;
    end else if (third_operand_stage_enable) begin
      third_stage_ff <= op_c;
    end
  end

  // Feeds the adder, the mask and the pattern alike, so all three see one stage
  always_comb begin
    if (ctrl_ff.third_operand_stage_count) begin
      third_operand = third_stage_ff;
    end else begin
      third_operand = op_c;
    end
  end

  // ---------------- Multiplier and X operand ----------------
  // Usage code 11 falls to the default and behaves as always
  always_comb begin
    case (ctrl_ff.mult_usage)
      mult_never:   use_product = 1'b0;
      mult_dynamic: use_product = mult_select;
      default:      use_product = 1'b1;
    endcase
  end

  // Inputs are held at zero when unused so the array does not toggle
  assign mult_active = (ctrl_ff.mult_usage != mult_never);
  assign mult_a      = mult_active ? op_a[24:0] : 25'h000_0000;
  assign mult_b      = mult_active ? op_b : 18'h0_0000;
  assign product     = 43'($signed(mult_a) * $signed(mult_b));

  // Product path for multiply-add, concatenation path otherwise
  assign product_ext = {{5{product[42]}}, product};
  assign concat_ab   = {op_a, op_b};
  assign x_operand   = use_product ? product_ext : concat_ab;

  // Subtract is third operand minus X, done as Z + ~X + 1 in each lane
  assign x_eff = ctrl_ff.subtract ? ~x_operand : x_operand;

  // ---------------- Lane-split adder ----------------
  // A set bit marks a segment that opens a lane and takes the lane carry-in
  always_comb begin
    case (ctrl_ff.adder_lane_split)
      dual_half_lanes:    lane_start = 4'b0101;
      quad_quarter_lanes: lane_start = 4'b1111;
      default:            lane_start = 4'b0001;
    endcase
  end

  assign carry_chain[0] = ctrl_ff.subtract;

  genvar seg;
  generate
    for (seg = 0; seg < 4; seg = seg + 1) begin : g_seg
      logic        cin;
      logic [12:0] seg_sum;
      // Carry is cut at each lane boundary so lanes stay independent
      assign cin = lane_start[seg] ? ctrl_ff.subtract : carry_chain[seg];
      assign seg_sum = {1'b0, third_operand[seg*12 +: 12]} +
                       {1'b0, x_eff[seg*12 +: 12]} + {12'h000, cin};
      assign sum[seg*12 +: 12] = seg_sum[11:0];
      assign carry_chain[seg+1] = seg_sum[12];
    end
  endgenerate

  // Each segment reports its own carry, lane boundary or not
  assign seg_carry = carry_chain[4:1];

  // ---------------- Result register and autoclear ----------------
  always_comb begin
    case (ctrl_ff.match_autoclear_policy)
      clear_on_match:   autoclear = detect_ff;
      clear_on_unmatch: autoclear = ~detect_ff & detect_prev_ff;
      default:          autoclear = 1'b0;
    endcase
  end

  // Without the result stage the register follows the sum every cycle
  assign result_load  = ~ctrl_ff.result_stage_used | output_stage_enable;
  // A clear outranks a load, so a match on a loading cycle still empties the register
  assign result_clear = ctrl_ff.result_stage_used & (output_stage_clear | autoclear);

  always_comb begin
    if (result_clear) begin
      nxt_result = 48'h0000_0000_0000;
    end else if (result_load) begin
      nxt_result = sum;
    end else begin
      nxt_result = result_ff;
    end
  end

  // Matching the value about to be stored keeps detect aligned with result
  pattern_matcher u_matcher (
    .value          (nxt_result),
    .third_operand  (third_operand),
    .static_cfg     (static_ff),
    .mask_source    (ctrl_ff.mask_source),
    .pattern_source (ctrl_ff.pattern_source),
    .match          (nxt_detect)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff <= 48'h0000_0000_0000;
    end else begin
      result_ff <= nxt_result;
    end
  end

  // Detect flags describe the value now held in result_ff
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_ff <= 1'b0;
    end else begin
      detect_ff <= nxt_detect;
    end
  end

  // One cycle of history is all that loss-of-match needs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_prev_ff <= 1'b0;
    end else begin
      detect_prev_ff <= detect_ff;
    end
  end

  // Carries share the result register's enable and clear
  always_comb begin
    if (result_clear) begin
      nxt_carry = 4'h0;
    end else if (result_load) begin
      nxt_carry = seg_carry;
    end else begin
      nxt_carry = carry_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_ff <= 4'h0;
    end else begin
      carry_ff <= nxt_carry;
    end
  end

  assign result         = result_ff;
  assign lane_carry     = carry_ff;
  assign pattern_detect = detect_ff;

endmodule // simd_adder_pattern_match

`default_nettype wire

// >>> tb/simd_adder_checker.sv
`timescale 1ns/1ps
`default_nettype none
module simd_adder_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        output_stage_enable,
  input wire logic        output_stage_clear,
  input wire logic [47:0] result,
  input wire logic [3:0]  lane_carry,
  input wire logic        pattern_detect,
  input wire logic        config_conflict
);
  logic acc;
  logic ctrl_wr_ff;
  assign acc = psel & penable;
  // Only a control write may move the conflict flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_wr_ff <= 1'b0;
    else ctrl_wr_ff <= acc & pwrite & (paddr == 8'h00);
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_always: assert property (acc |-> pready) else $error("no ready");
  a_err_unmapped: assert property (acc && paddr > 8'h1c |-> pslverr) else $error("no err");
  a_err_mapped: assert property (acc && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("false err");
  a_err_phase: assert property (pslverr |-> acc) else $error("err outside access");
  a_unmapped_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read data");
  a_clear_result: assert property (
    output_stage_clear |=> result == 48'h0 && lane_carry == 4'h0) else $error("clear missed");
  a_hold_result: assert property (
    !output_stage_enable && !output_stage_clear && !pattern_detect && !$past(pattern_detect)
    |=> $stable(result)) else $error("result moved");
  a_conflict_write: assert property ($changed(config_conflict) |-> ctrl_wr_ff)
    else $error("conflict moved");
  c_clear: cover property (output_stage_clear);
  c_detect: cover property ($rose(pattern_detect));
  c_unmapped: cover property (acc && pslverr);
endmodule // simd_adder_checker

bind simd_adder_pattern_match simd_adder_checker chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .output_stage_enable(output_stage_enable), .output_stage_clear(output_stage_clear),
  .result(result), .lane_carry(lane_carry), .pattern_detect(pattern_detect),
  .config_conflict(config_conflict)
);
`default_nettype wire

// >>> tb/fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
module fabric_model (
  input  wire logic   pclk,
  output logic [29:0] op_a,
  output logic [17:0] op_b,
  output logic [47:0] op_c,
  output logic        mult_select,
  output logic        c_en,
  output logic        c_clr,
  output logic        p_en,
  output logic        p_clr
);
  initial {op_a, op_b, op_c, mult_select, c_en, c_clr, p_en, p_clr} = '0;
  // Launch on the edge so the slice always gets a full cycle of setup
  task automatic put(input logic [29:0] a, input logic [17:0] b, input logic [47:0] c,
                     input logic [4:0] ctl);
    @(posedge pclk);
    op_a <= a;
    op_b <= b;
    op_c <= c;
    {mult_select, c_en, c_clr, p_en, p_clr} <= ctl;
  endtask
endmodule // fabric_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "simd_adder_regs.svh"
module testbench import simd_adder_pkg::*; ;
  localparam logic [47:0] pat = 48'h1234_5678_9abc;
  localparam logic [29:0] opa = 30'h3fff_fffd;
  localparam logic [17:0] opb = 18'h0_0005;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, mult_select, c_en, c_clr, p_en, p_clr;
  logic        pattern_detect, config_conflict;
  logic [29:0] op_a;
  logic [17:0] op_b;
  logic [47:0] op_c, result;
  logic [3:0]  lane_carry;
  int          err_count = 0, n_checks = 0, cyc = 0;

  always #5 pclk = ~pclk;

  simd_adder_pattern_match dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_a(op_a), .op_b(op_b), .op_c(op_c), .mult_select(mult_select),
    .third_operand_stage_enable(c_en), .third_operand_stage_clear(c_clr),
    .output_stage_enable(p_en), .output_stage_clear(p_clr), .result(result),
    .lane_carry(lane_carry), .pattern_detect(pattern_detect),
    .config_conflict(config_conflict)
  );
  fabric_model fab_u (
    .pclk(pclk), .op_a(op_a), .op_b(op_b), .op_c(op_c), .mult_select(mult_select),
    .c_en(c_en), .c_clr(c_clr), .p_en(p_en), .p_clr(p_clr)
  );

  task automatic give_verdict;
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic wr48(input logic [7:0] a, input logic [47:0] v);
    apb(1'b1, a, v[31:0]);
    apb(1'b1, a + 8'h4, {16'h0, v[47:32]});
  endtask

  task automatic tick;
    @(posedge pclk);
    #1;
  endtask

  // Carry is cut at every lane boundary of width w
  function automatic logic [47:0] lsum(input logic [47:0] x, z, input int w);
    logic c;
    c = 1'b0;
    for (int i = 0; i < 48; i++) begin
      if (i % w == 0) c = 1'b0;
      lsum[i] = x[i] ^ z[i] ^ c;
      c = (x[i] & z[i]) | (c & (x[i] ^ z[i]));
    end
  endfunction

  function automatic logic hit(input logic [47:0] v, p, m);
    return ((v ^ p) & ~m) == 48'h0;
  endfunction

  task automatic t_regs;
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, `CTRL_RESET);
    apb(1'b0, `OFS_MASK_HI, 32'h0);
    chk(rd, `MASK_RESET >> 32);
    apb(1'b1, 8'h20, 32'hffff_ffff);
    chk(er, 1);
    apb(1'b0, 8'h20, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    apb(1'b1, `OFS_CTRL, 32'hffff_ffff);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, `CTRL_WMASK);
  endtask

  task automatic t_lanes;
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, `OFS_CTRL, 32'h0800 | (s << 2));
      fab_u.put(30'h3fff_ffff, 18'h3_ffff, 48'h001_001_001_001, 5'b00010);
      tick;
      chk(result, lsum({48{1'b1}}, 48'h001_001_001_001, 48 / (1 << s)));
      chk(config_conflict, 0);
    end
    chk(lane_carry, 4'hf);
    apb(1'b1, `OFS_CTRL, 32'h0805);
    tick;
    chk(config_conflict, 1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(rd[`ST_CONFLICT], 1);
    // Each 24-bit lane works out the third operand minus X on its own
    apb(1'b1, `OFS_CTRL, 32'h1804);
    fab_u.put(30'h40, 18'h1, 48'h5, 5'b00010);
    tick;
    chk(result, 48'hffff_ff00_0004);
    chk(lane_carry, 4'h3);
    apb(1'b0, `OFS_RESULT_LO, 32'h0);
    chk(rd, 32'hff00_0004);
    apb(1'b0, `OFS_RESULT_HI, 32'h0);
    chk(rd, 32'h0000_ffff);
  endtask

  task automatic t_mult;
    logic [47:0] p;
    p = $signed(opa[24:0]) * $signed(opb);
    apb(1'b1, `OFS_CTRL, 32'h0801);
    fab_u.put(opa, opb, 48'h100, 5'b00010);
    tick;
    chk(result, 48'h100 + p);
    apb(1'b1, `OFS_CTRL, 32'h0802);
    fab_u.put(opa, opb, 48'h100, 5'b10010);
    tick;
    chk(result, 48'h100 + p);
    fab_u.put(opa, opb, 48'h100, 5'b00010);
    tick;
    chk(result, 48'h100 + {opa, opb});
    apb(1'b1, `OFS_CTRL, 32'h0800);
    fab_u.put(opa, opb, 48'h100, 5'b10010);
    tick;
    chk(result, 48'h100 + {opa, opb});
  endtask

  task automatic t_match;
    logic [47:0] x, msk;
    logic        exp_hit;
    wr48(`OFS_PATTERN_LO, pat + 48'h1);
    wr48(`OFS_MASK_LO, 48'hff);
    for (int d = 0; d < 2; d++) for (int m = 0; m < 4; m++) for (int p = 0; p < 2; p++) begin
      x = d ? 48'h100 : 48'h1;
      msk = m == 0 ? 48'hff : m == 1 ? pat : m == 2 ? ~pat << 1 : ~pat << 2;
      // The matcher-used bit toggles with d and must not change the outcome
      apb(1'b1, `OFS_CTRL, 32'h0800 | (m << 6) | (p << 8) | (d << 9));
      fab_u.put(x[47:18], x[17:0], pat, 5'b00010);
      tick;
      exp_hit = hit(lsum(x, pat, 48), p ? pat : pat + 48'h1, msk);
      chk(pattern_detect, exp_hit);
    end
    // Last case matches with no autoclear, so the result must stay put
    tick;
    chk(result, lsum(x, pat, 48));
  endtask

  task automatic t_clear;
    // Park the result at zero first so no stale match clears too early
    fab_u.put(30'h0, 18'h0, 48'h0, 5'b00001);
    apb(1'b1, `OFS_CTRL, 32'h0810);
    fab_u.put(30'h0, 18'h1, pat, 5'b00010);
    tick;
    chk(pattern_detect, 1);
    tick;
    chk(result, 48'h0);
    fab_u.put(30'h0, 18'h0, 48'h0, 5'b00001);
    apb(1'b1, `OFS_CTRL, 32'h0820);
    fab_u.put(30'h0, 18'h1, pat, 5'b00010);
    tick;
    chk(pattern_detect, 1);
    fab_u.put(30'h0, 18'h100, pat, 5'b00010);
    tick;
    chk(pattern_detect, 0);
    tick;
    chk(result, 48'h0);
    tick;
    chk(result, pat + 48'h100);
  endtask

  task automatic t_stages;
    apb(1'b1, `OFS_CTRL, 32'h0c00);
    fab_u.put(30'h0, 18'h0, 48'h5, 5'b01010);
    repeat (2) tick;
    chk(result, 48'h5);
    fab_u.put(30'h0, 18'h0, 48'h7, 5'b00010);
    repeat (2) tick;
    chk(result, 48'h5);
    fab_u.put(30'h0, 18'h0, 48'h7, 5'b01000);
    repeat (2) tick;
    chk(result, 48'h5);
    fab_u.put(30'h0, 18'h0, 48'h7, 5'b01110);
    repeat (2) tick;
    chk(result, 48'h0);
    fab_u.put(30'h0, 18'h0, 48'h7, 5'b01010);
    repeat (2) tick;
    chk(result, 48'h7);
    fab_u.put(30'h0, 18'h0, 48'h7, 5'b01011);
    tick;
    chk(result, 48'h0);
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    // The whole sequence needs well under a thousand cycles
    if (cyc == 5000) begin
      err_count++;
      give_verdict;
    end
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_lanes;
    t_mult;
    t_match;
    t_clear;
    t_stages;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
